// [shared/afth_pkg.sv]
// Constants for the alarm flag and alarm threshold register bank
package afth_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W   = 7;
  localparam int DATA_W   = 12;
  localparam int HYST_W   = 4;
  localparam int N_CHAN   = 8;
  localparam int GROUP_SZ = 4;

  // ----------------------------------------------------------------
  // Register offsets, page 0
  // ----------------------------------------------------------------
  localparam logic [6:0] OFS_CH_LO_GROUP_LATCHED = 7'h21;
  localparam logic [6:0] OFS_CH_LO_GROUP_LIVE    = 7'h22;
  localparam logic [6:0] OFS_CH_HI_GROUP_LATCHED = 7'h23;
  localparam logic [6:0] OFS_CH_HI_GROUP_LIVE    = 7'h24;
  localparam logic [6:0] OFS_PAGE_SELECT         = 7'h7f;

  // ----------------------------------------------------------------
  // Register offsets, page 1
  // ----------------------------------------------------------------
  localparam logic [6:0] OFS_TEMP_LOW_UPPER  = 7'h00;
  localparam logic [6:0] OFS_TEMP_LOW_LOWER  = 7'h01;
  localparam logic [6:0] OFS_TEMP_HIGH_UPPER = 7'h02;
  localparam logic [6:0] OFS_TEMP_HIGH_LOWER = 7'h03;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int HYST_MSB     = 7;
  localparam int HYST_LSB     = 4;
  localparam int THR_TOP_MSB  = 3;
  localparam int THR_TOP_LSB  = 0;
  localparam int PAGE_BIT     = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_TEMP_LOW_UPPER  = 8'h00;
  localparam logic [7:0] RST_TEMP_LOW_LOWER  = 8'h00;
  localparam logic [7:0] RST_TEMP_HIGH_UPPER = 8'h0f;
  localparam logic [7:0] RST_TEMP_HIGH_LOWER = 8'hff;
  localparam logic [7:0] RDATA_UNMAPPED      = 8'h00;

  // ----------------------------------------------------------------
  // Register page
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    AFTH_PAGE0 = 1'b0,
    AFTH_PAGE1 = 1'b1
  } afth_page_t;

endpackage

// [src/afth_regs.sv]
// Alarm flag and temperature alarm threshold register bank
`timescale 1ns/10ps
// Contract
// RULE_01 - High and low alarms exist for the temperature sensor and for each of eight channels, each evaluated alone.
// RULE_02 - Each channel threshold has an active flag and a tripped flag, four flags per channel.
// RULE_03 - An active flag sets when data cross its threshold and clears itself once the condition ends.
// RULE_04 - A tripped flag sets like its active flag but stays latched until its register is read.
// RULE_05 - Page 0 holds tripped ch0-3 at 21h, active ch0-3 at 22h, tripped ch4-7 at 23h, active ch4-7 at 24h.
// RULE_06 - In each flag byte the lowest channel sits at bits 7:6 down to the highest at 1:0, low flag upper.
// RULE_07 - A flag bit reads 1 when its alarm is detected and 0 otherwise.
// RULE_08 - The page register at 7Fh uses only bit 0, and the host writes zeros to bits 7:1.
// RULE_09 - After a page is chosen every later access goes to that page until the other is chosen.
// RULE_10 - After power-up and any reset page 0 is selected.
// RULE_11 - The host writes 01h to 7Fh to reach page 1 and 00h to return to page 0.
// RULE_12 - Each alarm setting is a 12-bit threshold and 4-bit hysteresis held in two 8-bit registers.
// RULE_13 - Page 1 offsets 00h to 03h hold temp low upper, temp low lower, temp high upper, temp high lower.
// RULE_14 - Upper-byte bits 7:4 give hysteresis in LSBs, 0 for none up to 15.
// RULE_15 - Upper-byte bits 3:0 are threshold bits 11:8 and the lower byte gives bits 7:0.
// RULE_16 - An alarm is signalled on the alarm/power-down pin so the host can read the flags.
// RULE_17 - High alarms assert above, low alarms below threshold, and release only past it by the hysteresis.
module afth_regs
  import afth_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Register access from the serial port decoder
  input  wire logic              reg_wr_en,
  input  wire logic              reg_rd_en,
  input  wire logic [6:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  output logic      [7:0]        reg_rdata,
  // Conversion results
  input  wire logic              conv_valid,
  input  wire logic [2:0]        conv_chan,
  input  wire logic [11:0]       conv_data,
  input  wire logic              temp_valid,
  input  wire logic [11:0]       temp_data,
  // Channel thresholds from the page 1 channel registers
  input  wire logic [95:0]       ch_high_thr,
  input  wire logic [31:0]       ch_high_hyst,
  input  wire logic [95:0]       ch_low_thr,
  input  wire logic [31:0]       ch_low_hyst,
  // Status
  output logic                   alarm_or_powerdown_pin,
  output logic                   page_sel,
  output logic                   temp_high_active,
  output logic                   temp_low_active
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // High alarm with hysteresis; 13-bit sum avoids wrap near full scale
  function automatic logic high_alarm(input logic [11:0] d, input logic [11:0] thr,
                                      input logic [3:0] hyst, input logic act);
    logic [12:0] sum;
    sum = {1'b0, d} + {9'h000, hyst};
    if (act) begin
      high_alarm = (sum > {1'b0, thr}); // RULE_17
    end else begin
      high_alarm = (d > thr); // RULE_17
    end
  endfunction

  // Low alarm with hysteresis
  function automatic logic low_alarm(input logic [11:0] d, input logic [11:0] thr,
                                     input logic [3:0] hyst, input logic act);
    logic [12:0] sum;
    sum = {1'b0, thr} + {9'h000, hyst};
    if (act) begin
      low_alarm = ({1'b0, d} < sum); // RULE_17
    end else begin
      low_alarm = (d < thr); // RULE_17
    end
  endfunction

  // Packs four channels into one flag byte
  function automatic logic [7:0] pack_group(input logic [3:0] lo, input logic [3:0] hi);
    logic [7:0] b;
    b = 8'h00;
    for (int k = 0; k < GROUP_SZ; k++) begin
      b[7 - 2 * k] = lo[k]; // RULE_06
      b[6 - 2 * k] = hi[k]; // RULE_06
    end
    pack_group = b;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  afth_page_t page_reg;
  logic [7:0] temp_low_upper_reg;
  logic [7:0] temp_low_lower_reg;
  logic [7:0] temp_high_upper_reg;
  logic [7:0] temp_high_lower_reg;
  logic [7:0] ch_high_act_reg;
  logic [7:0] ch_low_act_reg;
  logic [7:0] ch_high_trip_reg;
  logic [7:0] ch_low_trip_reg;
  logic       temp_high_act_reg;
  logic       temp_low_act_reg;
  logic [7:0] ch_high_act_next;
  logic [7:0] ch_low_act_next;
  logic [7:0] trip_clr;
  logic [7:0] sample_sel;
  logic       temp_high_act_next;
  logic       temp_low_act_next;
  logic [7:0] rdata_next;
  logic       on_page0;
  logic       on_page1;
  logic [11:0] temp_low_thr;
  logic [11:0] temp_high_thr;

  assign on_page0      = (page_reg == AFTH_PAGE0); // RULE_09
  assign on_page1      = (page_reg == AFTH_PAGE1); // RULE_09
  assign temp_low_thr  = {temp_low_upper_reg[THR_TOP_MSB:THR_TOP_LSB], temp_low_lower_reg}; // RULE_15
  assign temp_high_thr = {temp_high_upper_reg[THR_TOP_MSB:THR_TOP_LSB], temp_high_lower_reg}; // RULE_15

  // ----------------------------------------------------------------
  // Page select
  // ----------------------------------------------------------------
  // Reachable from both pages, otherwise page 1 would be a trap
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      page_reg <= AFTH_PAGE0; // RULE_10
    end else if (reg_wr_en && reg_addr == OFS_PAGE_SELECT) begin
      page_reg <= afth_page_t'(reg_wdata[PAGE_BIT]); // RULE_08 RULE_11
    end
  end

  // ----------------------------------------------------------------
  // Temperature alarm settings, page 1
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      temp_low_upper_reg  <= RST_TEMP_LOW_UPPER;
      temp_low_lower_reg  <= RST_TEMP_LOW_LOWER;
      temp_high_upper_reg <= RST_TEMP_HIGH_UPPER;
      temp_high_lower_reg <= RST_TEMP_HIGH_LOWER;
    end else if (reg_wr_en && on_page1) begin
      if (reg_addr == OFS_TEMP_LOW_UPPER) begin
        temp_low_upper_reg <= reg_wdata; // RULE_12 RULE_13
      end else if (reg_addr == OFS_TEMP_LOW_LOWER) begin
        temp_low_lower_reg <= reg_wdata; // RULE_13
      end else if (reg_addr == OFS_TEMP_HIGH_UPPER) begin
        temp_high_upper_reg <= reg_wdata; // RULE_13
      end else if (reg_addr == OFS_TEMP_HIGH_LOWER) begin
        temp_high_lower_reg <= reg_wdata; // RULE_13
      end
    end
  end

  // ----------------------------------------------------------------
  // Alarm evaluation
  // ----------------------------------------------------------------
  always_comb begin
    ch_high_act_next = ch_high_act_reg;
    ch_low_act_next  = ch_low_act_reg;
    if (conv_valid) begin
      ch_high_act_next[conv_chan] = high_alarm(conv_data, ch_high_thr[conv_chan * 12 +: 12],
                                               ch_high_hyst[conv_chan * 4 +: 4],
                                               ch_high_act_reg[conv_chan]); // RULE_01 RULE_03
      ch_low_act_next[conv_chan]  = low_alarm(conv_data, ch_low_thr[conv_chan * 12 +: 12],
                                              ch_low_hyst[conv_chan * 4 +: 4],
                                              ch_low_act_reg[conv_chan]); // RULE_01 RULE_03
    end
  end

  always_comb begin
    temp_high_act_next = temp_high_act_reg;
    temp_low_act_next  = temp_low_act_reg;
    if (temp_valid) begin
      temp_high_act_next = high_alarm(temp_data, temp_high_thr,
                                      temp_high_upper_reg[HYST_MSB:HYST_LSB], temp_high_act_reg); // RULE_01 RULE_14
      temp_low_act_next  = low_alarm(temp_data, temp_low_thr,
                                     temp_low_upper_reg[HYST_MSB:HYST_LSB], temp_low_act_reg); // RULE_01 RULE_14
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ch_high_act_reg   <= 8'h00;
      ch_low_act_reg    <= 8'h00;
      temp_high_act_reg <= 1'b0;
      temp_low_act_reg  <= 1'b0;
    end else begin
      ch_high_act_reg   <= ch_high_act_next; // RULE_02 RULE_03
      ch_low_act_reg    <= ch_low_act_next; // RULE_02 RULE_03
      temp_high_act_reg <= temp_high_act_next;
      temp_low_act_reg  <= temp_low_act_next;
    end
  end

  // ----------------------------------------------------------------
  // Tripped flags
  // ----------------------------------------------------------------
  // A read clears a group; a fresh alarm in that cycle still wins
  always_comb begin
    trip_clr = 8'h00;
    if (reg_rd_en && on_page0) begin
      if (reg_addr == OFS_CH_LO_GROUP_LATCHED) begin
        trip_clr = 8'h0f; // RULE_04
      end else if (reg_addr == OFS_CH_HI_GROUP_LATCHED) begin
        trip_clr = 8'hf0; // RULE_04
      end
    end
  end

  // Only a fresh sample sets a tripped flag, so a read can quiet a standing alarm
  always_comb begin
    sample_sel = 8'h00;
    if (conv_valid) begin
      sample_sel[conv_chan] = 1'b1; // RULE_04
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ch_high_trip_reg <= 8'h00;
      ch_low_trip_reg  <= 8'h00;
    end else begin
      ch_high_trip_reg <= (ch_high_trip_reg & ~trip_clr) | (ch_high_act_next & sample_sel); // RULE_02 RULE_04
      ch_low_trip_reg  <= (ch_low_trip_reg & ~trip_clr) | (ch_low_act_next & sample_sel); // RULE_02 RULE_04
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb begin
    rdata_next = RDATA_UNMAPPED;
    if (reg_addr == OFS_PAGE_SELECT) begin
      rdata_next = {7'h00, page_reg}; // RULE_08
    end else if (on_page0 && reg_addr == OFS_CH_LO_GROUP_LATCHED) begin
      rdata_next = pack_group(ch_low_trip_reg[3:0], ch_high_trip_reg[3:0]); // RULE_05 RULE_07
    end else if (on_page0 && reg_addr == OFS_CH_LO_GROUP_LIVE) begin
      rdata_next = pack_group(ch_low_act_reg[3:0], ch_high_act_reg[3:0]); // RULE_05 RULE_07
    end else if (on_page0 && reg_addr == OFS_CH_HI_GROUP_LATCHED) begin
      rdata_next = pack_group(ch_low_trip_reg[7:4], ch_high_trip_reg[7:4]); // RULE_05 RULE_07
    end else if (on_page0 && reg_addr == OFS_CH_HI_GROUP_LIVE) begin
      rdata_next = pack_group(ch_low_act_reg[7:4], ch_high_act_reg[7:4]); // RULE_05 RULE_07
    end else if (on_page1 && reg_addr == OFS_TEMP_LOW_UPPER) begin
      rdata_next = temp_low_upper_reg;
    end else if (on_page1 && reg_addr == OFS_TEMP_LOW_LOWER) begin
      rdata_next = temp_low_lower_reg;
    end else if (on_page1 && reg_addr == OFS_TEMP_HIGH_UPPER) begin
      rdata_next = temp_high_upper_reg;
    end else if (on_page1 && reg_addr == OFS_TEMP_HIGH_LOWER) begin
      rdata_next = temp_high_lower_reg;
    end
  end

  // Holds the last read value until the next read strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd_en) begin
      reg_rdata <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Status outputs
  // ----------------------------------------------------------------
  // Temperature has no flag register here, so its live level drives the pin
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      alarm_or_powerdown_pin <= 1'b0;
    end else begin
      alarm_or_powerdown_pin <= (|ch_high_trip_reg) | (|ch_low_trip_reg)
                                | temp_high_act_reg | temp_low_act_reg; // RULE_16
    end
  end

  assign page_sel         = page_reg;
  assign temp_high_active = temp_high_act_reg;
  assign temp_low_active  = temp_low_act_reg;

endmodule

// [tb/afth_regs_assertions.sv]
// Assertion checker for the alarm flag and threshold register bank
`timescale 1ns/10ps
module afth_regs_checker
  import afth_pkg::*;
(
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // Register port
  input wire logic       reg_wr_en,
  input wire logic       reg_rd_en,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Status
  input wire logic       alarm_or_powerdown_pin,
  input wire logic       page_sel,
  input wire logic       temp_high_active,
  input wire logic       temp_low_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence page_wr;
    reg_wr_en && reg_addr == OFS_PAGE_SELECT;
  endsequence
  sequence page_rd;
    reg_rd_en && reg_addr == OFS_PAGE_SELECT;
  endsequence
  // Offset 20h is left out: its flags live outside this block
  sequence unmap_rd;
    reg_rd_en && reg_addr != OFS_PAGE_SELECT && (reg_addr > 7'h24 || (!page_sel && reg_addr < 7'h20));
  endsequence
  chk_page_one: assert property (page_wr ##0 reg_wdata[0] |=> page_sel)
    else $error("page 1 not selected");
  chk_page_zero: assert property (page_wr ##0 !reg_wdata[0] |=> !page_sel)
    else $error("page 0 not selected");
  chk_page_hold: assert property (!(reg_wr_en && reg_addr == OFS_PAGE_SELECT) |=> $stable(page_sel))
    else $error("page moved without a write");
  chk_page_read: assert property (page_rd |=> reg_rdata == {7'h00, $past(page_sel)})
    else $error("page register read wrong");
  chk_rdata_hold: assert property (!reg_rd_en |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  chk_unmap_low: assert property (unmap_rd |=> reg_rdata == RDATA_UNMAPPED)
    else $error("unmapped read not zero");
  chk_unmap_page: assert property (reg_rd_en && page_sel && reg_addr > 7'h03 && reg_addr < 7'h25
    |=> reg_rdata == RDATA_UNMAPPED) else $error("page 1 unmapped read not zero");
  chk_pin_temp: assert property (temp_high_active || temp_low_active |=> alarm_or_powerdown_pin)
    else $error("alarm pin missed a temperature alarm");
endmodule
bind afth_regs afth_regs_checker u_afth_regs_checker (.clk, .rst, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata,
  .reg_rdata, .alarm_or_powerdown_pin, .page_sel, .temp_high_active, .temp_low_active);

// [tb/afth_host_model.sv]
// Host controller model for the register port
`timescale 1ns/10ps
module afth_host_model (
  // Clock
  input  wire logic       clk,
  // Register port
  output logic            reg_wr_en,
  output logic            reg_rd_en,
  output logic [6:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  initial {reg_wr_en, reg_rd_en, reg_addr, reg_wdata} = '0;
  // Idle lines invert so stale values never pass for valid ones
  task automatic xfer(input logic w, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge clk);
    {reg_wr_en, reg_rd_en} = {w, !w};
    {reg_addr, reg_wdata} = {a, d};
    @(negedge clk);
    {reg_wr_en, reg_rd_en} = 2'b00;
    {reg_addr, reg_wdata} = ~{a, d};
    q = reg_rdata;
  endtask
endmodule

// [tb/afth_regs_bench.sv]
// Self-checking bench for the alarm flag and threshold register bank
`timescale 1ns/10ps
`define CHK(n, e, g) check(n, e, g)
module afth_regs_bench
  import afth_pkg::*;
;
  logic        clk = 1'b0, rst = 1'b1, conv_valid = 1'b0, temp_valid = 1'b0;
  logic [2:0]  conv_chan = 3'h0;
  logic [11:0] conv_data = 12'h000, temp_data = 12'h000;
  logic        reg_wr_en, reg_rd_en, alarm_or_powerdown_pin, page_sel, temp_high_active, temp_low_active;
  logic [6:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, rv;
  int          miscompares = 0, checks_done = 0;
  always #20 clk = ~clk;
  afth_host_model u_afth_host_model (.clk, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata);
  afth_regs u_afth_regs (.clk, .rst, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata, .conv_valid,
    .conv_chan, .conv_data, .temp_valid, .temp_data, .ch_high_thr({8{12'h800}}), .ch_high_hyst({8{4'h2}}),
    .ch_low_thr({8{12'h100}}), .ch_low_hyst(32'h0), .alarm_or_powerdown_pin, .page_sel, .temp_high_active,
    .temp_low_active);
  task automatic check(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // A read hands the expected value where a write hands data
  task automatic rw(input logic w, input logic [6:0] a, input logic [7:0] d);
    u_afth_host_model.xfer(w, a, d, rv);
    if (!w) `CHK("reg_rdata", d, rv);
  endtask
  task automatic smp(input logic t, input logic [2:0] c, input logic [11:0] d, input logic [1:0] e);
    @(negedge clk);
    {temp_valid, conv_valid} = {t, !t};
    {conv_chan, conv_data, temp_data} = {c, d, d};
    @(negedge clk);
    {temp_valid, conv_valid} = 2'b00;
    if (t) `CHK("temp_flags", {6'h00, e}, {6'h00, temp_high_active, temp_low_active});
  endtask
  task automatic conclude;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    `CHK("page_sel", 8'h00, {7'h00, page_sel});
    rw(1'b0, OFS_PAGE_SELECT, 8'h00);
    rw(1'b0, OFS_TEMP_HIGH_UPPER, RDATA_UNMAPPED);
    for (logic [7:0] a = 8'h21; a < 8'h25; a++) rw(1'b0, a[6:0], 8'h00);
    rw(1'b1, OFS_PAGE_SELECT, 8'h01);
    rw(1'b0, OFS_PAGE_SELECT, 8'h01);
    rw(1'b0, OFS_TEMP_HIGH_LOWER, RST_TEMP_HIGH_LOWER);
    rw(1'b0, OFS_CH_LO_GROUP_LIVE, RDATA_UNMAPPED);
    rw(1'b1, OFS_TEMP_LOW_UPPER, 8'h35);
    rw(1'b1, OFS_TEMP_LOW_LOWER, 8'h00);
    rw(1'b1, OFS_TEMP_HIGH_UPPER, 8'h2a);
    rw(1'b1, OFS_TEMP_HIGH_LOWER, 8'h00);
    rw(1'b0, OFS_TEMP_LOW_UPPER, 8'h35);
    smp(1'b1, 3'h0, 12'ha01, 2'b10);
    smp(1'b1, 3'h0, 12'h9ff, 2'b10);
    smp(1'b1, 3'h0, 12'h9fe, 2'b00);
    smp(1'b1, 3'h0, 12'h4ff, 2'b01);
    @(negedge clk);
    `CHK("alarm_pin", 8'h01, {7'h00, alarm_or_powerdown_pin});
    smp(1'b1, 3'h0, 12'h502, 2'b01);
    smp(1'b1, 3'h0, 12'h503, 2'b00);
    rw(1'b1, OFS_PAGE_SELECT, 8'h00);
    for (int c = 0; c < 8; c++) smp(1'b0, 3'(c), 12'h900, 2'b00);
    rw(1'b0, OFS_CH_LO_GROUP_LIVE, 8'h55);
    rw(1'b0, OFS_CH_LO_GROUP_LATCHED, 8'h55);
    rw(1'b0, OFS_CH_LO_GROUP_LATCHED, 8'h00);
    rw(1'b0, OFS_CH_HI_GROUP_LATCHED, 8'h55);
    for (int c = 0; c < 8; c++) smp(1'b0, 3'(c), 12'h050, 2'b00);
    smp(1'b0, 3'h0, 12'h400, 2'b00);
    smp(1'b0, 3'h5, 12'h900, 2'b00);
    smp(1'b0, 3'h5, 12'h7ff, 2'b00);
    rw(1'b0, OFS_CH_LO_GROUP_LIVE, 8'h2a);
    rw(1'b0, OFS_CH_HI_GROUP_LIVE, 8'h9a);
    rw(1'b0, OFS_CH_LO_GROUP_LATCHED, 8'haa);
    rw(1'b0, OFS_CH_HI_GROUP_LATCHED, 8'hba);
    @(negedge clk);
    `CHK("alarm_pin", 8'h00, {7'h00, alarm_or_powerdown_pin});
    rw(1'b1, OFS_PAGE_SELECT, 8'h01);
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    `CHK("page_sel", 8'h00, {7'h00, page_sel});
    conclude();
  end
endmodule
